// ==== inc/ifos_pkg.sv ====
package ifos_pkg;

	// ==========================================================
	// Clock and timing
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned LS_STARTUP_NS = 40000;
	localparam int unsigned HS_STARTUP_NS = 45000;
	localparam int unsigned HS_BLANKING_NS = 200000;
	localparam int unsigned HS_FAULT_NS = 100000;
	// Least times round up to whole cycles
	localparam int unsigned LS_STARTUP_CYCLES = (LS_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned HS_STARTUP_CYCLES = (HS_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned HS_BLANKING_CYCLES =
		(HS_BLANKING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned HS_FAULT_CYCLES = (HS_FAULT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Link carrier
	localparam int unsigned CARRIER_DIV = 2;
	localparam int unsigned RX_HOLD_CYCLES = 6;
	localparam int unsigned COUNT_W = 16;

	// ==========================================================
	// Reset values
	localparam logic ALARM_RELEASED = 1'b1;
	localparam logic PIN_DRIVE_VALUE = 1'b0;
	// Synchroniser idle: trips clear, supplies missing, mode bipolar, lines released
	localparam logic [9:0] SYNC_RESET = 10'h03b;

	// ==========================================================
	// State encodings, Gray along the usual path
	typedef enum logic [1:0] {
		HS_OFF = 2'h0,
		HS_START = 2'h1,
		HS_BLANK = 2'h3,
		HS_RUN = 2'h2
	} ifos_hs_state_t;

	typedef enum logic [1:0] {
		LS_OFF = 2'h0,
		LS_START = 2'h1,
		LS_RUN = 2'h3
	} ifos_ls_state_t;

	// Window trip, negative half ignored in positive mode
	function automatic logic ifos_window_trip(
		input logic pos_trip,
		input logic neg_trip,
		input logic positive_only
	);
		return pos_trip | (neg_trip & ~positive_only);
	endfunction

endpackage

// ==== logic/ifos_ook_channel.sv ====
`timescale 1ns/1ns
module ifos_ook_channel #(
	parameter int unsigned RX_HOLD = ifos_pkg::RX_HOLD_CYCLES
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic carrier_tick,
	input wire logic tx_enable,
	input wire logic tx_bit,
	output logic rx_bit
);
	import ifos_pkg::*;

	localparam int HOLD_W = $clog2(RX_HOLD + 1);
	localparam int RX_LAT = RX_HOLD + 2;

	if (RX_HOLD <= 2 * CARRIER_DIV)
	begin : g_bad_hold
		$error("Receiver hold must outlast a carrier period");
	end

	logic carrier_r;
	logic carrier_d_r;
	logic [HOLD_W-1:0] hold_r;
	logic rx_bit_r;
	logic carrier_edge;
	logic tx_active;

	assign tx_active = tx_enable & tx_bit;
	assign carrier_edge = carrier_r ^ carrier_d_r;
	assign rx_bit = rx_bit_r;

	// ==========================================================
	// Transmit side
	// Carrier toggles for a one, line silent for a zero
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst || !tx_active)
			carrier_r <= 1'b0;
		else if (carrier_tick)
			carrier_r <= ~carrier_r;
	end

	// ==========================================================
	// Receive side
	// Edge detector retriggers a hold window
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			carrier_d_r <= 1'b0;
			hold_r <= '0;
			rx_bit_r <= 1'b0;
		end
		else
		begin
			carrier_d_r <= carrier_r;
			if (carrier_edge)
				hold_r <= HOLD_W'(RX_HOLD);
			else if (hold_r != '0)
				hold_r <= hold_r - 1'b1;
			rx_bit_r <= carrier_edge || (hold_r != '0);
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	chk_zero_silent: assert property (!tx_active |=> !carrier_r)
		else $error("Carrier sent for a zero");
	chk_rx_catch: assert property ($rose(carrier_r) |=> rx_bit_r)
		else $error("Carrier burst not detected");
	chk_rx_release: assert property (!tx_active [*3] |-> ##[1:RX_LAT] !rx_bit_r)
		else $error("Receiver did not release after carrier stopped");
	cov_burst: cover property (tx_active ##1 rx_bit_r);

endmodule

// ==== logic/ifos_sequencer.sv ====
`timescale 1ns/1ns
module ifos_sequencer #(
	parameter int unsigned LS_STA_CYC = ifos_pkg::LS_STARTUP_CYCLES,
	parameter int unsigned HS_STA_CYC = ifos_pkg::HS_STARTUP_CYCLES,
	parameter int unsigned HS_BLK_CYC = ifos_pkg::HS_BLANKING_CYCLES,
	parameter int unsigned HS_FLT_CYC = ifos_pkg::HS_FAULT_CYCLES,
	parameter int unsigned CNT_W = ifos_pkg::COUNT_W
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic adjustable_positive_comparator,
	input wire logic adjustable_negative_comparator,
	input wire logic fixed_positive_comparator,
	input wire logic fixed_negative_comparator,
	input wire logic high_side_undervoltage,
	input wire logic high_side_power_on_reset,
	input wire logic low_side_undervoltage,
	input wire logic mode_select_above,
	input wire logic adjustable_window_alarm_n_level,
	output logic adjustable_window_alarm_n_drv,
	output logic adjustable_window_alarm_n_oe_n,
	input wire logic fixed_window_alarm_n_level,
	output logic fixed_window_alarm_n_drv,
	output logic fixed_window_alarm_n_oe_n,
	output logic [1:0] alarm_line_low
);
	import ifos_pkg::*;

	// Refuse counts the counters cannot hold
	if (LS_STA_CYC < 1 || HS_STA_CYC < 1 || HS_BLK_CYC < 1 || HS_FLT_CYC < 1)
	begin : g_bad_zero
		$error("Timing counts must be at least one cycle");
	end
	if (HS_BLK_CYC >= (1 << CNT_W) || HS_FLT_CYC >= (1 << CNT_W) ||
		HS_STA_CYC >= (1 << CNT_W) || LS_STA_CYC >= (1 << CNT_W))
	begin : g_bad_width
		$error("Timing count exceeds counter width");
	end

	// ==========================================================
	// Input synchronisers
	logic [9:0] meta_r;
	logic [9:0] sync_r;
	logic adj_pos_s;
	logic adj_neg_s;
	logic fix_pos_s;
	logic fix_neg_s;
	logic hs_uv_s;
	logic hs_por_s;
	logic ls_uv_s;
	logic mode_pos_s;
	logic adj_level_s;
	logic fix_level_s;

	// Two stages for every pin-level flag
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			meta_r <= SYNC_RESET;
			sync_r <= SYNC_RESET;
		end
		else
		begin
			meta_r <= {adjustable_positive_comparator, adjustable_negative_comparator,
				fixed_positive_comparator, fixed_negative_comparator,
				high_side_undervoltage, high_side_power_on_reset,
				low_side_undervoltage, mode_select_above,
				adjustable_window_alarm_n_level, fixed_window_alarm_n_level};
			sync_r <= meta_r;
		end
	end

	// Named views of the second stage
	assign {adj_pos_s, adj_neg_s, fix_pos_s, fix_neg_s, hs_uv_s, hs_por_s,
		ls_uv_s, mode_pos_s, adj_level_s, fix_level_s} = sync_r;

	// ==========================================================
	// Comparator decode and isolation link
	logic adj_trip;
	logic fix_trip;
	localparam int DIV_W = $clog2(CARRIER_DIV);
	logic [DIV_W-1:0] div_cnt_r;
	logic carrier_tick_r;
	logic rx_adj;
	logic rx_fix;
	logic tx_enable;
	ifos_hs_state_t hs_state_r;

	// Negative halves masked in positive mode
	assign adj_trip = ifos_window_trip(adj_pos_s, adj_neg_s, mode_pos_s);
	assign fix_trip = ifos_window_trip(fix_pos_s, fix_neg_s, mode_pos_s);

	// Nothing crosses the barrier before blanking ends
	assign tx_enable = (hs_state_r == HS_RUN);

	// Carrier rate enable
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			div_cnt_r <= '0;
			carrier_tick_r <= 1'b0;
		end
		else
		begin
			carrier_tick_r <= (div_cnt_r == '0);
			if (div_cnt_r == DIV_W'(CARRIER_DIV - 1))
				div_cnt_r <= '0;
			else
				div_cnt_r <= div_cnt_r + 1'b1;
		end
	end

	// One channel per window
	ifos_ook_channel #(
		.RX_HOLD(RX_HOLD_CYCLES)
	) u_adj_link (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.carrier_tick(carrier_tick_r),
		.tx_enable(tx_enable),
		.tx_bit(adj_trip),
		.rx_bit(rx_adj)
	);

	ifos_ook_channel #(
		.RX_HOLD(RX_HOLD_CYCLES)
	) u_fix_link (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.carrier_tick(carrier_tick_r),
		.tx_enable(tx_enable),
		.tx_bit(fix_trip),
		.rx_bit(rx_fix)
	);

	// ==========================================================
	// High-side supply sequencing
	logic [CNT_W-1:0] hs_cnt_r;
	logic hs_ok;

	// Startup then blanking; brownout keeps the run state
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			hs_state_r <= HS_OFF;
			hs_cnt_r <= '0;
		end
		else
		begin
			case (hs_state_r)
				HS_OFF:
				begin
					hs_cnt_r <= '0;
					if (!hs_por_s && !hs_uv_s)
						hs_state_r <= HS_START;
				end
				HS_START:
				begin
					if (hs_por_s || hs_uv_s)
					begin
						hs_state_r <= HS_OFF;
						hs_cnt_r <= '0;
					end
					else if (hs_cnt_r == CNT_W'(HS_STA_CYC - 1))
					begin
						hs_state_r <= HS_BLANK;
						hs_cnt_r <= '0;
					end
					else
						hs_cnt_r <= hs_cnt_r + 1'b1;
				end
				HS_BLANK:
				begin
					if (hs_por_s || hs_uv_s)
					begin
						hs_state_r <= HS_OFF;
						hs_cnt_r <= '0;
					end
					else if (hs_cnt_r == CNT_W'(HS_BLK_CYC - 1))
					begin
						hs_state_r <= HS_RUN;
						hs_cnt_r <= '0;
					end
					else
						hs_cnt_r <= hs_cnt_r + 1'b1;
				end
				HS_RUN:
				begin
					hs_cnt_r <= '0;
					if (hs_por_s)
						hs_state_r <= HS_OFF;
				end
				default:
				begin
					hs_state_r <= HS_OFF;
					hs_cnt_r <= '0;
				end
			endcase
		end
	end

	// Live data only with a running, healthy high side
	assign hs_ok = (hs_state_r == HS_RUN) && !hs_uv_s;

	// ==========================================================
	// Low-side supply sequencing
	ifos_ls_state_t ls_state_r;
	logic [CNT_W-1:0] ls_cnt_r;
	logic ls_run;

	// Startup count from each low-side power-up
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			ls_state_r <= LS_OFF;
			ls_cnt_r <= '0;
		end
		else
		begin
			case (ls_state_r)
				LS_OFF:
				begin
					ls_cnt_r <= '0;
					if (!ls_uv_s)
						ls_state_r <= LS_START;
				end
				LS_START:
				begin
					if (ls_uv_s)
					begin
						ls_state_r <= LS_OFF;
						ls_cnt_r <= '0;
					end
					else if (ls_cnt_r == CNT_W'(LS_STA_CYC - 1))
						ls_state_r <= LS_RUN;
					else
						ls_cnt_r <= ls_cnt_r + 1'b1;
				end
				LS_RUN:
				begin
					ls_cnt_r <= '0;
					if (ls_uv_s)
						ls_state_r <= LS_OFF;
				end
				default:
				begin
					ls_state_r <= LS_OFF;
					ls_cnt_r <= '0;
				end
			endcase
		end
	end

	// Undervoltage acts at once, before the state updates
	assign ls_run = (ls_state_r == LS_RUN) && !ls_uv_s;

	// ==========================================================
	// High-side fault timer
	logic [CNT_W-1:0] flt_cnt_r;
	logic fault_r;

	// Counts while the high side is missing, restarts on recovery
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst || !ls_run || hs_ok)
		begin
			flt_cnt_r <= '0;
			fault_r <= 1'b0;
		end
		else if (!fault_r)
		begin
			if (flt_cnt_r == CNT_W'(HS_FLT_CYC - 1))
				fault_r <= 1'b1;
			else
				flt_cnt_r <= flt_cnt_r + 1'b1;
		end
	end

	// ==========================================================
	// Alarm output drivers
	logic adj_oe_n_r;
	logic fix_oe_n_r;
	logic adj_oe_n_nxt;
	logic fix_oe_n_nxt;
	logic drive_val_r;
	logic [1:0] line_low_r;

	// Release, follow, fault low, or hold through a short dip
	always_comb
	begin
		adj_oe_n_nxt = adj_oe_n_r;
		fix_oe_n_nxt = fix_oe_n_r;
		if (!ls_run)
		begin
			adj_oe_n_nxt = ALARM_RELEASED;
			fix_oe_n_nxt = ALARM_RELEASED;
		end
		else if (hs_ok)
		begin
			adj_oe_n_nxt = !rx_adj;
			fix_oe_n_nxt = !rx_fix;
		end
		else if (fault_r)
		begin
			adj_oe_n_nxt = !ALARM_RELEASED;
			fix_oe_n_nxt = !ALARM_RELEASED;
		end
	end

	// Enables start released after reset
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			adj_oe_n_r <= ALARM_RELEASED;
			fix_oe_n_r <= ALARM_RELEASED;
		end
		else
		begin
			adj_oe_n_r <= adj_oe_n_nxt;
			fix_oe_n_r <= fix_oe_n_nxt;
		end
	end

	// Pin value is always low; only the enable moves
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			drive_val_r <= PIN_DRIVE_VALUE;
		else
			drive_val_r <= PIN_DRIVE_VALUE;
	end

	// Line readback, high bit is adjustable window
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			line_low_r <= '0;
		else
			line_low_r <= {!adj_level_s, !fix_level_s};
	end

	assign adjustable_window_alarm_n_oe_n = adj_oe_n_r;
	assign fixed_window_alarm_n_oe_n = fix_oe_n_r;
	assign adjustable_window_alarm_n_drv = drive_val_r;
	assign fixed_window_alarm_n_drv = drive_val_r;
	assign alarm_line_low = line_low_r;

	// ==========================================================
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	chk_ls_uv_release: assert property (!ls_run |=> adj_oe_n_r && fix_oe_n_r)
		else $error("Alarm driven without low-side supply");
	chk_fault_drives_low: assert property (ls_run && !hs_ok && fault_r
		|=> !adj_oe_n_r && !fix_oe_n_r)
		else $error("Fault did not pull both alarms low");
	chk_fault_delay_len: assert property ($rose(fault_r)
		|-> $past(flt_cnt_r) == CNT_W'(HS_FLT_CYC - 1))
		else $error("Fault raised at wrong count");
	chk_short_dip_hold: assert property (ls_run && !hs_ok && !fault_r
		|=> $stable(adj_oe_n_r) && $stable(fix_oe_n_r))
		else $error("Alarm moved during a short dip");
	chk_follow_live: assert property (ls_run && hs_ok
		|=> adj_oe_n_r == !$past(rx_adj) && fix_oe_n_r == !$past(rx_fix))
		else $error("Alarm not following the live state");
	chk_hs_startup_len: assert property (hs_state_r == HS_BLANK && $past(hs_state_r) == HS_START
		|-> $past(hs_cnt_r) == CNT_W'(HS_STA_CYC - 1))
		else $error("High-side startup length wrong");
	chk_blank_len: assert property (hs_state_r == HS_RUN && $past(hs_state_r) == HS_BLANK
		|-> $past(hs_cnt_r) == CNT_W'(HS_BLK_CYC - 1))
		else $error("Blanking length wrong");
	chk_ls_startup_len: assert property ($rose(ls_state_r == LS_RUN)
		|-> $past(ls_cnt_r) == CNT_W'(LS_STA_CYC - 1))
		else $error("Low-side startup length wrong");
	chk_por_restart: assert property (hs_por_s |=> hs_state_r == HS_OFF)
		else $error("Power loss did not restart the high side");
	chk_mode_positive: assert property (mode_pos_s
		|-> adj_trip == adj_pos_s && fix_trip == fix_pos_s)
		else $error("Negative comparator active in positive mode");
	chk_fault_clears: assert property (hs_ok |=> !fault_r)
		else $error("Fault held after high side recovered");

	cov_fault_raised: cover property (ls_run ##1 $rose(fault_r));
	cov_run_reached: cover property ($rose(hs_state_r == HS_RUN) ##1 ls_run);
	cov_brownout_back: cover property (fault_r && hs_state_r == HS_RUN ##1 hs_ok);

endmodule

// ==== tb/ifos_alarm_reader.sv ====
`timescale 1ns/1ns
// ==========================================================
// System controller side: pulled-up open-drain alarm lines
module ifos_alarm_reader (
	input wire logic adj_drv,
	input wire logic adj_oe_n,
	input wire logic fix_drv,
	input wire logic fix_oe_n,
	output logic adj_level,
	output logic fix_level,
	output logic [1:0] seen_low
);
	// Released line floats up to the pull-up level
	assign adj_level = adj_oe_n ? 1'b1 : adj_drv;
	assign fix_level = fix_oe_n ? 1'b1 : fix_drv;
	// Controller reads a low line as an active alarm
	assign seen_low = {~adj_level, ~fix_level};
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
// ==========================================================
// Self-checking bench for the alarm output sequencer
module testbench;
	import ifos_pkg::*;
	localparam int CEILING = 20000;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic ap = 1'b0, an = 1'b0, fp = 1'b0, fn = 1'b0, msel = 1'b0;
	logic hs_uv = 1'b1, hs_por = 1'b1, ls_uv = 1'b1;
	logic adj_lvl, adj_drv, adj_oe_n, fix_lvl, fix_drv, fix_oe_n;
	logic [1:0] line_low, seen_low;
	int n_mismatch = 0, checks = 0, cyc = 0;
	int phase = 0, tv = 0, tm = 0;

	// ==========================================================
	// Clock, design and controller model
	always #10 sys_clk = ~sys_clk;

	ifos_sequencer #(.LS_STA_CYC(4), .HS_STA_CYC(5), .HS_BLK_CYC(20), .HS_FLT_CYC(10)) u_dut (
		.sys_clk(sys_clk), .sys_rst(sys_rst),
		.adjustable_positive_comparator(ap), .adjustable_negative_comparator(an),
		.fixed_positive_comparator(fp), .fixed_negative_comparator(fn),
		.high_side_undervoltage(hs_uv), .high_side_power_on_reset(hs_por),
		.low_side_undervoltage(ls_uv), .mode_select_above(msel),
		.adjustable_window_alarm_n_level(adj_lvl), .adjustable_window_alarm_n_drv(adj_drv),
		.adjustable_window_alarm_n_oe_n(adj_oe_n),
		.fixed_window_alarm_n_level(fix_lvl), .fixed_window_alarm_n_drv(fix_drv),
		.fixed_window_alarm_n_oe_n(fix_oe_n), .alarm_line_low(line_low)
	);

	ifos_alarm_reader u_reader (
		.adj_drv(adj_drv), .adj_oe_n(adj_oe_n), .fix_drv(fix_drv), .fix_oe_n(fix_oe_n),
		.adj_level(adj_lvl), .fix_level(fix_lvl), .seen_low(seen_low)
	);

	// ==========================================================
	// Model: 0 released, 1 fault low, 2 following the windows
	function automatic logic [1:0] model_low();
		if (phase == 0)
			return 2'h0;
		if (phase == 1)
			return 2'h3;
		return {logic'(tv[3] || (tv[2] && tm == 0)), logic'(tv[1] || (tv[0] && tm == 0))};
	endfunction

	task automatic compare(input string what, input logic [1:0] exp, input logic [1:0] got);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask

	// Sample on the falling edge, return to a rising edge
	task automatic expect_now(input string what);
		@(negedge sys_clk);
		compare({what, " sync"}, model_low(), line_low);
		compare({what, " wire"}, model_low(), seen_low);
		@(posedge sys_clk);
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic set_trips(input int v, input int m);
		tv = v;
		tm = m;
		{ap, an, fp, fn} <= v[3:0];
		msel <= m[0];
	endtask

	task automatic do_reset();
		sys_rst <= 1'b1;
		hs_uv <= 1'b1;
		hs_por <= 1'b1;
		ls_uv <= 1'b1;
		phase = 0;
		step(10);
		sys_rst <= 1'b0;
		step(1);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ==========================================================
	// Hang guard
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == CEILING)
		begin
			n_mismatch++;
			$display("mismatch timeout expected finish seen hang");
			conclude();
		end
	end

	// ==========================================================
	// Main sequence
	initial
	begin
		void'($urandom(34));
		do_reset();
		expect_now("reset");
		// Low side alone: released, then no-power fault
		ls_uv <= 1'b0;
		step(12);
		expect_now("ls up");
		step(18);
		phase = 1;
		expect_now("no power");
		// High side comes up long after: blanking then follow
		hs_por <= 1'b0;
		hs_uv <= 1'b0;
		step(15);
		expect_now("blanking");
		step(35);
		phase = 2;
		expect_now("late hs");
		$display("test power-up done");
		// Short gap between supplies: fault first, normal later
		do_reset();
		ls_uv <= 1'b0;
		step(2);
		hs_por <= 1'b0;
		hs_uv <= 1'b0;
		step(22);
		phase = 1;
		expect_now("short gap");
		step(36);
		phase = 2;
		expect_now("short gap run");
		$display("test short gap done");
		// Every trip code in both modes, then random ones
		for (int i = 0; i < 32; i++)
		begin
			set_trips(i % 16, i / 16);
			step(16);
			expect_now("window");
		end
		for (int i = 0; i < 16; i++)
		begin
			set_trips($urandom % 16, $urandom % 2);
			step(16);
			expect_now("random window");
		end
		$display("test windows done");
		// Short dip leaves outputs alone
		set_trips(4, 0);
		step(16);
		hs_uv <= 1'b1;
		step(5);
		expect_now("dip mid");
		hs_uv <= 1'b0;
		step(5);
		expect_now("dip end");
		// Long brownout: fault, then immediate resume
		hs_uv <= 1'b1;
		step(20);
		phase = 1;
		expect_now("brownout");
		hs_uv <= 1'b0;
		step(15);
		phase = 2;
		expect_now("brownout end");
		$display("test brownout done");
		// Power loss: fault, then startup plus blanking
		hs_por <= 1'b1;
		hs_uv <= 1'b1;
		step(20);
		phase = 1;
		expect_now("power loss");
		hs_por <= 1'b0;
		hs_uv <= 1'b0;
		step(12);
		expect_now("loss recover");
		step(40);
		phase = 2;
		expect_now("loss run");
		$display("test power loss done");
		// Low side drop releases from follow and from fault
		ls_uv <= 1'b1;
		step(6);
		phase = 0;
		expect_now("ls drop run");
		ls_uv <= 1'b0;
		step(20);
		hs_uv <= 1'b1;
		step(20);
		phase = 1;
		expect_now("fault again");
		ls_uv <= 1'b1;
		step(6);
		phase = 0;
		expect_now("ls drop fault");
		// Low side returns with high side running
		hs_uv <= 1'b0;
		step(4);
		ls_uv <= 1'b0;
		step(2);
		expect_now("ls return");
		step(18);
		phase = 2;
		expect_now("ls late");
		$display("test low side done");
		conclude();
	end
endmodule
